// ### rtl/bmp_pkg.sv
/*
 bmp_pkg: constants for the backend memory port.
 Assumes a single 40 MHz core clock.
*/
package bmp_pkg;

  localparam int unsigned CLK_MHZ         = 40;
  // permitted access time in ns, path disabled / enabled
  localparam int unsigned ACC_NS_SLOW     = 9790;
  localparam int unsigned ACC_NS_FAST     = 4790;
  // longest time rounds down
  localparam int unsigned ACC_CYC_SLOW    = (ACC_NS_SLOW * CLK_MHZ) / 1000;
  localparam int unsigned ACC_CYC_FAST    = (ACC_NS_FAST * CLK_MHZ) / 1000;
  localparam int unsigned TMR_W           = 16;
  localparam logic [15:0] ADDR_RST        = 16'h0000;
  localparam logic [15:0] DATA_RST        = 16'h0000;

  typedef enum logic [2:0] {
    BMP_IDLE,
    BMP_SETUP,
    BMP_STROBE,
    BMP_HOLD,
    BMP_FAIL
  } bmp_state_e;

endpackage : bmp_pkg

// ### rtl/bmp_sync2.sv
/*
 bmp_sync2: two-flop synchroniser for a single level.
 Assumes the input is asynchronous to clk_i.
*/
`timescale 1ns/1ps
module bmp_sync2 #(
  parameter logic RST_VAL = 1'b1
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // level
  input  wire logic d_i,
  output logic      q_o
);

  logic meta_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= RST_VAL;
      q_o    <= RST_VAL;
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end

endmodule : bmp_sync2

// ### rtl/bmp_backend_port.sv
/*
 bmp_backend_port: backend memory port of a bus controller. Performs
 16-bit read/write cycles in synchronous or asynchronous mode, with
 request/grant arbitration, wait stretching and an access timeout.
 Assumes grant and wait are synchronous to core_clk_i; strap inputs
 and the timeout clear are synchronised here.
*/
// Operation
// R01: keep request low while further cycles must follow immediately.
// R02: arbiter grants access when requested, active-low grant.
// R03: grant is synchronous to core clock, may be tied low.
// R04: upper strobe writes bits 15..8, lower writes bits 7..0.
// R05: sync write on clock edge, strobe held while wait is low.
// R06: sync read samples next edge, or the edge wait goes high.
// R07: async strobe low at least one clock, stretched by wait.
// R08: async write: address and data one clock before, one after.
// R09: async read: address one clock before and one after strobe.
// R10: async read data captured as read strobe returns high.
// R11: chip select has the same timing as the address.
// R12: wait is synchronous, low means stretch; may tie high.
// R13: control drive enable only while requesting and granted.
// R14: data drive enable while requesting, granted and writing.
// R15: access time runs from request low until strobes high.
// R16: path enabled gives the shorter permitted access time.
// R17: timeout sets failure flag and halts further cycles.
// R18: async select one picks async cycles, zero sync.
// R19: failure flag cleared by host write to interrupt register.
// R20: host accesses pass only while memory path enable is one.
// R21: idle: request, select, enables inactive, strobes high.
`timescale 1ns/1ps
module bmp_backend_port
  import bmp_pkg::*;
#(
  parameter int unsigned AW         = 16,
  parameter int unsigned DW         = 16,
  parameter int unsigned TMO_SLOW   = ACC_CYC_SLOW,
  parameter int unsigned TMO_FAST   = ACC_CYC_FAST
) (
  // clock and reset
  input  wire logic          core_clk_i,
  input  wire logic          rst_i,
  // straps and control
  input  wire logic          async_backend_select_i,
  input  wire logic          host_memory_path_enable_i,
  input  wire logic          fail_clear_i,
  // controller request side
  input  wire logic          bc_req_i,
  input  wire logic          bc_write_i,
  input  wire logic [1:0]    bc_byte_en_i,
  input  wire logic [AW-1:0] bc_addr_i,
  input  wire logic [DW-1:0] bc_wdata_i,
  input  wire logic          bc_more_i,
  output logic               bc_ready_o,
  output logic               bc_done_o,
  output logic [DW-1:0]      bc_rdata_o,
  // host request side
  input  wire logic          host_req_i,
  input  wire logic          host_write_i,
  input  wire logic [1:0]    host_byte_en_i,
  input  wire logic [AW-1:0] host_addr_i,
  input  wire logic [DW-1:0] host_wdata_i,
  output logic               host_ready_o,
  output logic               host_done_o,
  output logic [DW-1:0]      host_rdata_o,
  // memory side
  output logic               memory_request_low_o,
  input  wire logic          bus_grant_low_i,
  output logic [1:0]         byte_write_strobes_low_o,
  output logic               read_strobe_low_o,
  output logic               ram_select_low_o,
  input  wire logic          hold_off_low_i,
  output logic [AW-1:0]      backend_address_o,
  output logic [DW-1:0]      write_word_out_o,
  input  wire logic [DW-1:0] read_word_in_i,
  output logic               control_drive_enable_o,
  output logic               data_drive_enable_o,
  output logic               access_timeout_flag_o
);

  ////////////////////////////////////////////////////////////////////////
  // strap and clear synchronisers

  logic async_s;
  logic path_en_s;
  logic clr_s;
  logic clr_d1_q;

  bmp_sync2 #(.RST_VAL(1'b0)) u_sync_async (
    .clk_i (core_clk_i),
    .rst_i (rst_i),
    .d_i   (async_backend_select_i),
    .q_o   (async_s)
  );

  bmp_sync2 #(.RST_VAL(1'b0)) u_sync_path (
    .clk_i (core_clk_i),
    .rst_i (rst_i),
    .d_i   (host_memory_path_enable_i),
    .q_o   (path_en_s)
  );

  bmp_sync2 #(.RST_VAL(1'b0)) u_sync_clr (
    .clk_i (core_clk_i),
    .rst_i (rst_i),
    .d_i   (fail_clear_i),
    .q_o   (clr_s)
  );

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      clr_d1_q <= 1'b0;
    end else begin
      clr_d1_q <= clr_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state and cycle registers

  bmp_state_e          state_q;
  logic                mode_async_q;
  logic                write_q;
  logic                host_q;
  logic [1:0]          be_q;
  logic [AW-1:0]       addr_q;
  logic [DW-1:0]       wdata_q;
  logic                req_low_q;
  logic                fail_q;
  logic [TMR_W-1:0]    tmr_q;
  logic [TMR_W-1:0]    tmo_lim;
  logic                granted;
  logic                hold_off;
  logic                host_ok;
  logic                take;
  logic                pick_host;
  logic                strobe_end;
  logic                timeout;

  assign granted   = ~bus_grant_low_i;
  assign hold_off  = ~hold_off_low_i;
  assign host_ok   = host_req_i & path_en_s; // R20
  // host access yields to the controller; controller has priority
  assign pick_host = host_ok & ~bc_req_i;
  // a cycle is taken only once the request has been seen low: a grant
  // left over from the previous cycle must not start a new one
  assign take      = (state_q == BMP_IDLE) & ~timeout & ~fail_q & granted &
                     req_low_q & (bc_req_i | host_ok);
  // last strobe cycle: wait released
  assign strobe_end = (state_q == BMP_STROBE) & ~hold_off; // R05 R07
  assign tmo_lim   = path_en_s ? TMR_W'(TMO_FAST) : TMR_W'(TMO_SLOW); // R16
  assign timeout   = req_low_q & (tmr_q >= tmo_lim); // R15

  // next cycle for the controller may chain straight on
  logic chain;
  assign chain = bc_more_i & bc_req_i & ~fail_q;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state_q <= BMP_IDLE;
    end else if (timeout) begin
      state_q <= BMP_FAIL; // R17
    end else begin
      case (state_q)
        BMP_IDLE: begin
          if (take) begin
            state_q <= async_s ? BMP_SETUP : BMP_STROBE; // R18
          end
        end
        BMP_SETUP: begin
          state_q <= BMP_STROBE; // R08 R09
        end
        BMP_STROBE: begin
          if (!hold_off) begin
            state_q <= mode_async_q ? BMP_HOLD : BMP_IDLE;
          end
        end
        BMP_HOLD: begin
          state_q <= BMP_IDLE; // R08 R09
        end
        BMP_FAIL: begin
          if (clr_s & ~clr_d1_q) begin
            state_q <= BMP_IDLE; // R19
          end
        end
        default: begin
          state_q <= BMP_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // request, latched cycle and timeout

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      req_low_q <= 1'b0;
    end else if (timeout | fail_q) begin
      // release the arbiter at once; nothing more runs until the clear
      req_low_q <= 1'b0;
    end else if (state_q == BMP_IDLE) begin
      req_low_q <= bc_req_i | host_ok; // R01
    end else if ((strobe_end & ~mode_async_q) | (state_q == BMP_HOLD)) begin
      req_low_q <= chain; // R01 R21
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      mode_async_q <= 1'b0;
      write_q      <= 1'b0;
      host_q       <= 1'b0;
      be_q         <= 2'b00;
      addr_q       <= ADDR_RST;
      wdata_q      <= DATA_RST;
    end else if (take) begin
      mode_async_q <= async_s;
      host_q       <= pick_host;
      write_q      <= pick_host ? host_write_i : bc_write_i;
      be_q         <= pick_host ? host_byte_en_i : bc_byte_en_i;
      addr_q       <= pick_host ? host_addr_i : bc_addr_i;
      wdata_q      <= pick_host ? host_wdata_i : bc_wdata_i;
    end
  end

  // measured from request low; cleared once both strobes are back high
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      tmr_q <= '0;
    end else if (!req_low_q || (state_q == BMP_HOLD) ||
                 (strobe_end & ~mode_async_q)) begin
      tmr_q <= '0; // R15
    end else if (tmr_q != '1) begin
      tmr_q <= tmr_q + TMR_W'(1);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      fail_q <= 1'b0;
    end else if (timeout) begin
      // set wins over a clear landing in the same cycle
      fail_q <= 1'b1; // R17
    end else if (clr_s & ~clr_d1_q) begin
      fail_q <= 1'b0; // R19
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read capture

  logic capture;
  // sync: edge where wait is high; async: edge that raises the strobe
  assign capture = strobe_end & ~write_q; // R06 R10

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      bc_done_o   <= 1'b0;
      host_done_o <= 1'b0;
    end else begin
      bc_done_o   <= strobe_end & ~host_q;
      host_done_o <= strobe_end & host_q;
    end
  end

  // read data stands until the next read of the same requester
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      bc_rdata_o   <= DATA_RST;
      host_rdata_o <= DATA_RST;
    end else begin
      if (capture & ~host_q) begin
        bc_rdata_o <= read_word_in_i;
      end
      if (capture & host_q) begin
        host_rdata_o <= read_word_in_i;
      end
    end
  end

  assign bc_ready_o   = take & ~pick_host;
  assign host_ready_o = take & pick_host;

  ////////////////////////////////////////////////////////////////////////
  // memory pins

  logic in_cycle;
  logic in_strobe;
  assign in_cycle  = (state_q == BMP_SETUP) | (state_q == BMP_STROBE) |
                     (state_q == BMP_HOLD);
  assign in_strobe = (state_q == BMP_STROBE);

  assign memory_request_low_o     = ~req_low_q;
  assign ram_select_low_o         = ~in_cycle; // R11
  assign backend_address_o        = addr_q; // R08 R09
  assign write_word_out_o         = wdata_q; // R08
  assign byte_write_strobes_low_o = ~({2{in_strobe & write_q}} & be_q); // R04
  assign read_strobe_low_o        = ~(in_strobe & ~write_q); // R21
  assign control_drive_enable_o   = req_low_q & granted & in_cycle; // R13
  assign data_drive_enable_o      = req_low_q & granted & in_cycle &
                                    write_q; // R14
  assign access_timeout_flag_o    = fail_q;

endmodule : bmp_backend_port

// ### verif/bmp_mem_model.sv
/*
 bmp_mem_model: arbiter and 64k x 16 RAM on the memory side.
 Assumes active-low controls driven by the backend port.
*/
`timescale 1ns/1ps
module bmp_mem_model (
  // clock, reset, test controls
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic        deny_i,
  input  wire logic        slow_i,
  // memory side
  input  wire logic        memory_request_low_i,
  input  wire logic [1:0]  byte_write_strobes_low_i,
  input  wire logic        read_strobe_low_i,
  input  wire logic        ram_select_low_i,
  input  wire logic [15:0] backend_address_i,
  input  wire logic [15:0] write_word_out_i,
  output logic             bus_grant_low_o,
  output logic             hold_off_low_o,
  output logic [15:0]      read_word_in_o
);
  logic [15:0] mem_q [0:65535];
  logic [1:0]  wcnt_q;
  logic        rd_was_q;
  logic        act;
  ////////////////////////////////////////////////////////////////
  assign act = !read_strobe_low_i || !(&byte_write_strobes_low_i);
  always_ff @(posedge core_clk_i) begin
    bus_grant_low_o <= rst_i || deny_i || memory_request_low_i;
  end
  always_ff @(posedge core_clk_i) begin
    wcnt_q   <= act ? wcnt_q + 2'(wcnt_q != 2'h3) : 2'h0;
    rd_was_q <= !read_strobe_low_i;
  end
  // two wait cycles at the start of each strobe when slow
  assign hold_off_low_o = !(slow_i && act && wcnt_q < 2'h2);
  always_ff @(posedge core_clk_i) begin
    if (!ram_select_low_i && hold_off_low_o) begin
      if (!byte_write_strobes_low_i[1])
        mem_q[backend_address_i][15:8] <= write_word_out_i[15:8];
      if (!byte_write_strobes_low_i[0])
        mem_q[backend_address_i][7:0] <= write_word_out_i[7:0];
    end
  end
  // outside a read and the cycle after it the bus shows the inverse, never a stale word
  assign read_word_in_o = (!read_strobe_low_i || rd_was_q) ?
    mem_q[backend_address_i] : ~mem_q[backend_address_i];
endmodule : bmp_mem_model

// ### verif/bmp_backend_port_chk.sv
/*
 bmp_backend_port_chk: memory side assertions.
 Assumes one clock and a synchronous reset.
*/
`timescale 1ns/1ps
module bmp_backend_port_chk #(
  parameter int unsigned AW = 16,
  parameter int unsigned DW = 16
) (
  // clock, reset, inputs
  input  wire logic          core_clk_i,
  input  wire logic          rst_i,
  input  wire logic          async_backend_select_i,
  input  wire logic          bus_grant_low_i,
  input  wire logic          hold_off_low_i,
  // memory outputs
  input  wire logic          memory_request_low_o,
  input  wire logic [1:0]    byte_write_strobes_low_o,
  input  wire logic          read_strobe_low_o,
  input  wire logic          ram_select_low_o,
  input  wire logic [AW-1:0] backend_address_o,
  input  wire logic [DW-1:0] write_word_out_o,
  input  wire logic          control_drive_enable_o,
  input  wire logic          data_drive_enable_o,
  input  wire logic          access_timeout_flag_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////
  cen_grant_a: assert property (
    control_drive_enable_o |-> !memory_request_low_o && !bus_grant_low_i)
    else $error("control enable without grant");
  den_write_a: assert property (
    data_drive_enable_o |-> control_drive_enable_o && read_strobe_low_o)
    else $error("data enable outside a write");
  strobe_cs_a: assert property (
    !read_strobe_low_o || !(&byte_write_strobes_low_o) |->
      !ram_select_low_o && control_drive_enable_o)
    else $error("strobe without select");
  wr_stretch_a: assert property (
    !(&byte_write_strobes_low_o) && !hold_off_low_i |=>
      $stable(byte_write_strobes_low_o))
    else $error("write strobe ended in wait");
  rd_stretch_a: assert property (
    !read_strobe_low_o && !hold_off_low_i |=> !read_strobe_low_o)
    else $error("read strobe ended in wait");
  async_setup_a: assert property (
    async_backend_select_i && ($fell(read_strobe_low_o) ||
      $fell(&byte_write_strobes_low_o)) |-> $stable(backend_address_o)
      && $stable(write_word_out_o) && !$past(ram_select_low_o))
    else $error("address not set up before strobe");
  async_hold_a: assert property (
    async_backend_select_i && ($rose(read_strobe_low_o) ||
      $rose(&byte_write_strobes_low_o)) |-> $stable(backend_address_o)
      && $stable(write_word_out_o) && !ram_select_low_o)
    else $error("address not held after strobe");
  fail_quiet_a: assert property (
    access_timeout_flag_o |-> !control_drive_enable_o &&
      read_strobe_low_o && &byte_write_strobes_low_o)
    else $error("cycle while timed out");
endmodule : bmp_backend_port_chk
bind bmp_backend_port bmp_backend_port_chk #(.AW(AW), .DW(DW)) i_chk (
  .core_clk_i(core_clk_i), .rst_i(rst_i),
  .async_backend_select_i(async_backend_select_i),
  .bus_grant_low_i(bus_grant_low_i), .hold_off_low_i(hold_off_low_i),
  .memory_request_low_o(memory_request_low_o),
  .byte_write_strobes_low_o(byte_write_strobes_low_o),
  .read_strobe_low_o(read_strobe_low_o),
  .ram_select_low_o(ram_select_low_o),
  .backend_address_o(backend_address_o),
  .write_word_out_o(write_word_out_o),
  .control_drive_enable_o(control_drive_enable_o),
  .data_drive_enable_o(data_drive_enable_o),
  .access_timeout_flag_o(access_timeout_flag_o)
);

// ### verif/tb_bmp_backend_port.sv
/*
 tb_bmp_backend_port: self-checking bench for the backend port.
 Assumes bmp_mem_model on the memory side and the bound checker.
*/
`timescale 1ns/1ps
module tb_bmp_backend_port;
  import bmp_pkg::*;
  // short timeouts keep the failure runs brief
  localparam int TS = 20;
  localparam int TF = 10;
  logic        clk, rst, asel, pen, fclr, bcr, hr, w, more, deny, slow;
  logic        brdy, bdone, hrdy, hdone, req_n, gnt_n, rd_n, cs_n;
  logic        wt_n, cen, den, fl;
  logic [1:0]  be, wr_n, bx;
  logic [15:0] a, d, brd, hrd, addr, dout, din;
  logic [15:0] ref_m [16];
  int          miscompares, tests_run, seed, n, k;
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  bmp_backend_port #(.TMO_SLOW(TS), .TMO_FAST(TF)) i_dut (
    .core_clk_i(clk), .rst_i(rst), .async_backend_select_i(asel),
    .host_memory_path_enable_i(pen), .fail_clear_i(fclr),
    .bc_req_i(bcr), .bc_write_i(w), .bc_byte_en_i(be), .bc_addr_i(a),
    .bc_wdata_i(d), .bc_more_i(more), .bc_ready_o(brdy),
    .bc_done_o(bdone), .bc_rdata_o(brd), .host_req_i(hr),
    .host_write_i(w), .host_byte_en_i(be), .host_addr_i(a),
    .host_wdata_i(d), .host_ready_o(hrdy), .host_done_o(hdone),
    .host_rdata_o(hrd), .memory_request_low_o(req_n),
    .bus_grant_low_i(gnt_n), .byte_write_strobes_low_o(wr_n),
    .read_strobe_low_o(rd_n), .ram_select_low_o(cs_n),
    .hold_off_low_i(wt_n), .backend_address_o(addr),
    .write_word_out_o(dout), .read_word_in_i(din),
    .control_drive_enable_o(cen), .data_drive_enable_o(den),
    .access_timeout_flag_o(fl)
  );
  bmp_mem_model i_mem (
    .core_clk_i(clk), .rst_i(rst), .deny_i(deny), .slow_i(slow),
    .memory_request_low_i(req_n), .byte_write_strobes_low_i(wr_n),
    .read_strobe_low_i(rd_n), .ram_select_low_i(cs_n),
    .backend_address_i(addr), .write_word_out_i(dout),
    .bus_grant_low_o(gnt_n), .hold_off_low_o(wt_n),
    .read_word_in_o(din)
  );
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] e, g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop
  task automatic wt(input int s, lim);
    logic v;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      v = s == 0 ? brdy : s == 1 ? hrdy : s == 2 ? bdone :
          s == 3 ? hdone : fl;
    end while (v !== 1'b1 && n < lim);
    if (v !== 1'b1) begin
      miscompares++;
      $display("[FAIL] wait %0d exp 1 got 0", s);
      report_and_stop;
    end
  endtask : wt
  task automatic op(input logic h, wi, input logic [1:0] bi,
                    input int ai);
    logic [15:0] di;
    di = 16'($random(seed));
    @(posedge clk);
    w    <= wi;
    be   <= bi;
    a    <= 16'(ai);
    d    <= di;
    slow <= 1'($random(seed));
    if (h) hr <= 1'b1;
    else bcr <= 1'b1;
    wt(int'(h), 60);
    hr  <= 1'b0;
    bcr <= 1'b0;
    wt(int'(h) + 2, 60);
    if (wi) begin
      if (bi[1]) ref_m[ai][15:8] = di[15:8];
      if (bi[0]) ref_m[ai][7:0] = di[7:0];
    end else chk("rdata", ref_m[ai], h ? hrd : brd);
  endtask : op
  ////////////////////////////////////////////////////////////////
  initial begin
    seed = 47758;
    {rst, asel, pen, fclr, bcr, hr, w, more, deny, slow} = 10'h200;
    {be, a, d} = 34'h0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    for (int m = 0; m < 2; m++) begin
      asel <= m[0];
      more <= 1'b1;
      pen  <= 1'b0;
      repeat (4) @(posedge clk);
      for (k = 0; k < 16; k++) op(1'b0, 1'b1, 2'h3, k);
      for (k = 0; k < 40; k++) begin
        more <= k < 39;
        bx = 2'($random(seed));
        op(1'b0, 1'($random(seed)), bx | {1'b0, !bx[1]},
           $random(seed) & 15);
      end
      pen <= 1'b1;
      repeat (4) @(posedge clk);
      op(1'b1, 1'b1, 2'h3, 5);
      op(1'b1, 1'b0, 2'h3, 5);
    end
    // two chained writes: the request must stay low between them
    @(posedge clk);
    w    <= 1'b1;
    be   <= 2'h3;
    a    <= 16'h0006;
    d    <= 16'hA5C3;
    more <= 1'b1;
    bcr  <= 1'b1;
    wt(0, 60);
    a <= 16'h0007;
    d <= 16'h5A3C;
    k = 0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      k += int'(req_n !== 1'b0);
    end while (brdy !== 1'b1 && n < 60);
    if (brdy !== 1'b1) begin
      miscompares++;
      $display("[FAIL] chain ready exp 1 got 0");
      report_and_stop;
    end
    bcr  <= 1'b0;
    more <= 1'b0;
    wt(2, 60);
    chk("chain gap", 16'h0, 16'(k));
    ref_m[6] = 16'hA5C3;
    ref_m[7] = 16'h5A3C;
    op(1'b0, 1'b0, 2'h3, 6);
    op(1'b0, 1'b0, 2'h3, 7);
    pen <= 1'b0;
    repeat (4) @(posedge clk);
    hr <= 1'b1;
    k = 0;
    repeat (30) begin
      @(posedge clk);
      k += int'(hrdy !== 1'b0);
    end
    hr <= 1'b0;
    chk("host refused", 16'h0, 16'(k));
    for (int m = 0; m < 2; m++) begin
      pen  <= m[0];
      deny <= 1'b1;
      repeat (4) @(posedge clk);
      bcr <= 1'b1;
      wt(4, 600);
      chk("timeout", 1'b1, n >= (m ? TF : TS) - 3 &&
          n <= (m ? TF : TS) + 6);
      bcr  <= 1'b0;
      deny <= 1'b0;
      repeat (3) @(posedge clk);
      chk("flag held", 1'b1, fl);
      fclr <= 1'b1;
      repeat (4) @(posedge clk);
      fclr <= 1'b0;
      repeat (4) @(posedge clk);
      chk("flag clear", 1'b0, fl);
    end
    op(1'b0, 1'b0, 2'h3, 5);
    report_and_stop;
  end
endmodule : tb_bmp_backend_port
